// file: rtl/uvlic_pkg.sv
package uvlic_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SEC_CYCLES = CLK_HZ;
  // apb register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_POWER = 8'h04;
  localparam logic [7:0] OFF_EXPO = 8'h08;
  localparam logic [7:0] OFF_THRESH = 8'h0C;
  localparam logic [7:0] OFF_CHILL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_TEMP = 8'h18;
  localparam logic [7:0] OFF_TIMER = 8'h1C;
  localparam logic [7:0] OFF_TOTAL = 8'h20;
  localparam logic [7:0] OFF_KEY = 8'h24;
  // control register bits
  localparam int B_AUTO = 0;
  localparam int B_CHEN = 1;
  localparam int B_SCREEN = 2;
  localparam int B_START = 3;
  localparam int B_STOP = 4;
  localparam int B_RESTORE = 5;
  localparam int B_CLRTOT = 6;
  // limits and factory values
  localparam logic [6:0] MIN_POWER = 7'h01;
  localparam logic [6:0] MAX_POWER = 7'h64;
  localparam logic [13:0] MAX_EXPO = 14'h270F;
  localparam logic [6:0] MAX_THRESH = 7'h41;
  localparam logic [6:0] DEF_POWER = 7'h50;
  localparam logic [13:0] DEF_EXPO = 14'h003C;
  localparam logic [6:0] DEF_THRESH = 7'h41;
  localparam logic [15:0] DEF_CHILL = 16'h003C;
  // arbitrary credential value
  localparam logic [31:0] DEF_KEY = 32'h0000_A5C3;
  typedef struct packed {
    logic [6:0] power;
    logic [13:0] expo;
    logic [6:0] thresh;
    logic [15:0] chill;
  } uvlic_cfg_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_COOL = 2'b11
  } uvlic_state_t;
endpackage : uvlic_pkg

// file: rtl/uvlic_top.sv
`timescale 1ns/1ns
`default_nettype none
module uvlic_top
  import uvlic_pkg::*;
#(
  parameter int unsigned SEC_CNT = SEC_CYCLES,
  parameter logic [31:0] ADMIN_KEY = DEF_KEY
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] lamp_temp,
  input wire logic chiller_ok,
  input wire logic contact_on,
  output logic lamp_on,
  output logic [6:0] lamp_power,
  output logic chiller_run,
  output logic alarm,
  output logic alarm_relay_contact
);
  ////////////////////////////////////////////////////////////////
  uvlic_cfg_t cfg;
  uvlic_state_t state, next_state;
  logic auto_mode, chan_en, screen, admin, overtemp, contact_q;
  logic [7:0] temp;
  logic [31:0] pre;
  logic [15:0] timer;
  logic [31:0] total;
  logic [31:0] next_rdata;
  logic next_err;
  // bus decode
  logic access, wr, wr_ctrl, tick;
  assign access = psel & penable & pready;
  assign wr = access & pwrite;
  // a refused control write must leave every control bit and strobe untouched
  assign wr_ctrl = wr && !pslverr && paddr == OFF_CTRL;
  assign tick = pre == SEC_CNT - 1;
  // start and stop sources
  logic start_req, stop_req, leave, start_ok, overheat, kill, chan_now, auto_now;
  // a control write that enables the channel and starts in one word takes effect at once
  assign chan_now = wr_ctrl ? pwdata[B_CHEN] : chan_en;
  assign auto_now = wr_ctrl ? pwdata[B_AUTO] : auto_mode;
  assign leave = wr_ctrl & screen & ~pwdata[B_SCREEN];
  assign start_req = (wr_ctrl & pwdata[B_START]) | (contact_on & ~contact_q);
  assign stop_req = (wr_ctrl & pwdata[B_STOP]) | (~contact_on & contact_q);
  assign start_ok = chan_now & chiller_ok & ~overtemp & ~leave;
  assign overheat = lamp_on & (temp > {1'b0, cfg.thresh});
  assign kill = overheat | ~chan_now | leave;
  ////////////////////////////////////////////////////////////////
  // apb setup-phase range and admin checks
  logic bad_wr;
  always_comb begin
    bad_wr = 1'b0;
    case (paddr)
      OFF_POWER: bad_wr = pwdata > {25'h0, MAX_POWER} || pwdata < {25'h0, MIN_POWER};
      OFF_EXPO: bad_wr = pwdata > {18'h0, MAX_EXPO};
      OFF_THRESH: bad_wr = pwdata > {25'h0, MAX_THRESH};
      OFF_CHILL: bad_wr = ~admin || pwdata[31:16] != 16'h0000;
      OFF_CTRL: bad_wr = ~admin & (pwdata[B_RESTORE] | pwdata[B_CLRTOT]);
      default: bad_wr = 1'b0;
    endcase
  end
  // read mux and error answer
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      OFF_CTRL: next_rdata = {29'h0, screen, chan_en, auto_mode};
      OFF_POWER: next_rdata = {25'h0, cfg.power};
      OFF_EXPO: next_rdata = {18'h0, cfg.expo};
      OFF_THRESH: next_rdata = {25'h0, cfg.thresh};
      OFF_CHILL: next_rdata = {16'h0, cfg.chill};
      OFF_STATUS: next_rdata = {26'h0, admin, overtemp, alarm, chiller_run, state == ST_COOL, lamp_on};
      OFF_TEMP: next_rdata = {24'h0, temp};
      OFF_TIMER: next_rdata = {16'h0, timer};
      OFF_TOTAL: next_rdata = total;
      OFF_KEY: next_rdata = 32'h0000_0000;
      default: next_err = 1'b1;
    endcase
    if (pwrite) begin
      next_rdata = 32'h0000_0000;
      next_err = next_err | bad_wr;
    end
  end
  // zero-wait slave: answer in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & next_err;
      prdata <= (psel & ~penable) ? next_rdata : 32'h0000_0000;
    end
  end
  ////////////////////////////////////////////////////////////////
  // control bits and credential
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_mode <= 1'b0;
      chan_en <= 1'b0;
      screen <= 1'b0;
      admin <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        auto_mode <= pwdata[B_AUTO];
        chan_en <= pwdata[B_CHEN];
        screen <= pwdata[B_SCREEN];
      end
      if (wr && paddr == OFF_KEY)
        admin <= pwdata == ADMIN_KEY;
    end
  end
  // settings with range checks and factory restore
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '{power: DEF_POWER, expo: DEF_EXPO, thresh: DEF_THRESH, chill: DEF_CHILL};
    end else if (wr && !pslverr) begin
      case (paddr)
        OFF_POWER: cfg.power <= pwdata[6:0];
        OFF_EXPO: cfg.expo <= pwdata[13:0];
        OFF_THRESH: cfg.thresh <= pwdata[6:0];
        OFF_CHILL: cfg.chill <= pwdata[15:0];
        OFF_CTRL: if (pwdata[B_RESTORE]) begin
          cfg.power <= DEF_POWER;
          cfg.expo <= DEF_EXPO;
          cfg.thresh <= DEF_THRESH;
        end
        default: cfg <= cfg;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // temperature sampling and self-clearing over-temperature flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp <= 8'h00;
      overtemp <= 1'b0;
      contact_q <= 1'b0;
    end else begin
      temp <= lamp_temp;
      contact_q <= contact_on;
      if (overheat)
        overtemp <= 1'b1;
      else if (temp < {1'b0, cfg.thresh})
        overtemp <= 1'b0;
    end
  end
  // lamp sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (start_req & start_ok) next_state = ST_RUN;
      ST_RUN: if (stop_req | kill | (auto_mode & timer == 16'h0000)) next_state = ST_COOL;
      ST_COOL: if (start_req & start_ok) next_state = ST_RUN;
        else if (timer == 16'h0000 & ~contact_on) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      lamp_on <= 1'b0;
      chiller_run <= 1'b0;
      lamp_power <= 7'h00;
      alarm <= 1'b0;
      alarm_relay_contact <= 1'b0;
    end else begin
      state <= next_state;
      lamp_on <= next_state == ST_RUN;
      chiller_run <= next_state != ST_IDLE;
      lamp_power <= next_state == ST_RUN ? cfg.power : 7'h00;
      alarm <= overtemp | overheat | (screen & ~chiller_ok);
      alarm_relay_contact <= overtemp | overheat | (screen & ~chiller_ok);
    end
  end
  // seconds prescaler, exposure and delay timer, total
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= 32'h0;
      timer <= 16'h0000;
      total <= 32'h0;
    end else begin
      pre <= (state == ST_IDLE || state != next_state || tick) ? 32'h0 : pre + 32'h1;
      if (next_state == ST_RUN && state != ST_RUN)
        timer <= auto_now ? {2'b00, cfg.expo} : 16'h0000;
      else if (next_state == ST_COOL && state == ST_RUN)
        timer <= cfg.chill;
      else if (tick && state == ST_RUN && !auto_mode && timer != 16'hFFFF)
        timer <= timer + 16'h1;
      else if (tick && timer != 16'h0000 && (state == ST_COOL || auto_mode))
        timer <= timer - 16'h1;
      if (wr_ctrl && !pslverr && pwdata[B_CLRTOT])
        total <= 32'h0;
      else if (tick && state == ST_RUN)
        total <= total + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_chiller_refuse: assert property (state == ST_IDLE && !chiller_ok |=> !lamp_on)
    else $error("lamp lit with chiller stopped");
  chk_chan_off: assert property (lamp_on |-> chan_en)
    else $error("lamp lit with channel disabled");
  chk_overheat_off: assert property (overheat |=> !lamp_on && alarm)
    else $error("overheat did not stop lamp");
  chk_temp_release: assert property (!overheat && temp < {1'b0, cfg.thresh} |=> !overtemp)
    else $error("alarm not released");
  chk_ot_refuse: assert property (overtemp && state != ST_RUN |=> !lamp_on)
    else $error("start during alarm");
  chk_power_level: assert property (lamp_on |-> lamp_power == $past(cfg.power))
    else $error("lamp power mismatch");
  chk_power_range: assert property (cfg.power >= MIN_POWER && cfg.power <= MAX_POWER)
    else $error("power out of range");
  chk_chill_hold: assert property ($fell(lamp_on) |-> chiller_run)
    else $error("chiller dropped with lamp");
  chk_auto_end: assert property (state == ST_RUN && auto_mode && timer == 16'h0000 |=> !lamp_on)
    else $error("auto exposure overran");
  chk_leave_off: assert property (leave |=> !lamp_on)
    else $error("lamp stayed on after leaving screen");
  chk_total_clear: assert property ($fell(total != 32'h0) && $past(state) != ST_RUN |-> $past(admin))
    else $error("total cleared without credential");
  // power output is zero whenever the lamp is dark
  chk_power_dark: assert property (!lamp_on |-> lamp_power == 7'h00)
    else $error("power driven with lamp dark");
  // relay contact mirrors the alarm output
  chk_relay_mirror: assert property (alarm_relay_contact == alarm)
    else $error("relay contact differs from alarm");
  // chiller always runs while lit
  chk_chill_lit: assert property (lamp_on |-> chiller_run)
    else $error("lamp lit without chiller");
  // chiller output tracks the non-idle states
  chk_chill_state: assert property (chiller_run == (state != ST_IDLE))
    else $error("chiller output out of step");
  // lamp output tracks the run state
  chk_lamp_state: assert property (lamp_on == (state == ST_RUN))
    else $error("lamp output out of step");
  // manual exposure has no timed end
  chk_manual_hold: assert property (state == ST_RUN && !auto_mode && !stop_req && !kill |=> lamp_on)
    else $error("manual exposure ended by itself");
  // accepted start lights the lamp next cycle
  chk_start_on: assert property (state == ST_IDLE && start_req && start_ok |=> lamp_on)
    else $error("accepted start did not light lamp");
  // stopped chiller on the irradiation screen raises alarm
  chk_alarm_chill: assert property (screen && !chiller_ok |=> alarm)
    else $error("no alarm with chiller stopped");
  // alarm drops once no cause remains
  chk_alarm_clear: assert property (!overtemp && !overheat && !(screen && !chiller_ok) |=> !alarm)
    else $error("alarm stuck without cause");
  // stored threshold never beyond its limit
  chk_thresh_range: assert property (cfg.thresh <= MAX_THRESH)
    else $error("threshold out of range");
  // stored exposure never beyond its limit
  chk_expo_range: assert property (cfg.expo <= MAX_EXPO)
    else $error("exposure out of range");
  // every lit second adds one to the total unless a clear comes in the same cycle
  chk_total_step: assert property (state == ST_RUN && tick && !(wr_ctrl && pwdata[B_CLRTOT]) |=> total == $past(total) + 32'h1)
    else $error("total missed a second");
  // total holds while dark and untouched
  chk_total_hold: assert property (state != ST_RUN && !wr_ctrl |=> $stable(total))
    else $error("total moved while dark");
  // a clear of the total is only carried out with the credential
  chk_clear_admin: assert property (wr_ctrl && pwdata[B_CLRTOT] |-> admin)
    else $error("clear carried out without credential");
  // restore loads factory values
  chk_restore_vals: assert property (wr_ctrl && pwdata[B_RESTORE] |=> cfg.power == DEF_POWER && cfg.expo == DEF_EXPO && cfg.thresh == DEF_THRESH)
    else $error("restore values wrong");
  // chiller stops when the delay ends with no request
  chk_cool_end: assert property (state == ST_COOL && timer == 16'h0000 && !contact_on && !(start_req && start_ok) |=> !chiller_run)
    else $error("chiller kept after delay");
  // stop request darkens the lamp
  chk_stop_honour: assert property (state == ST_RUN && stop_req |=> !lamp_on)
    else $error("stop request ignored");
  // matching key grants the credential
  chk_key_grant: assert property (wr && paddr == OFF_KEY && pwdata == ADMIN_KEY |=> admin)
    else $error("valid key not accepted");
  // wrong key withdraws the credential
  chk_key_deny: assert property (wr && paddr == OFF_KEY && pwdata != ADMIN_KEY |=> !admin)
    else $error("wrong key accepted");
  // temperature register follows the pin one clock later
  chk_temp_follow: assert property (presetn && $past(presetn) |-> temp == $past(lamp_temp))
    else $error("temperature not sampled");
  // ready stands for one cycle only
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  // error answer only comes with ready
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule : uvlic_top
`default_nettype wire

// file: dv/uvlic_far_side.sv
`timescale 1ns/1ns
`default_nettype none
module uvlic_far_side
  import uvlic_pkg::*;
(
  input wire logic pclk,
  input wire logic [7:0] temp_set,
  input wire logic chill_on,
  input wire logic contact_req,
  output logic [7:0] lamp_temp,
  output logic chiller_ok,
  output logic contact_on
);
  // sensor, chiller status and foot contact follow their commands one clock later
  always_ff @(posedge pclk) begin
    lamp_temp <= temp_set;
    chiller_ok <= chill_on;
    contact_on <= contact_req;
  end
endmodule : uvlic_far_side
`default_nettype wire

// file: dv/uvlic_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module uvlic_top_bench
  import uvlic_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, temp_set = 8'h14;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, chill_on = 1, contact_req = 0;
  logic [7:0] lamp_temp;
  logic chiller_ok, contact_on, lamp_on, chiller_run, alarm, relay;
  logic [6:0] lamp_power;
  int fail_count = 0, comparisons = 0;
  // clock of 40 ns
  always #20 pclk = ~pclk;
  uvlic_top #(.SEC_CNT(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lamp_temp(lamp_temp), .chiller_ok(chiller_ok), .contact_on(contact_on), .lamp_on(lamp_on),
    .lamp_power(lamp_power), .chiller_run(chiller_run), .alarm(alarm), .alarm_relay_contact(relay));
  uvlic_far_side i_far (.pclk(pclk), .temp_set(temp_set), .chill_on(chill_on), .contact_req(contact_req),
    .lamp_temp(lamp_temp), .chiller_ok(chiller_ok), .contact_on(contact_on));
  ////////////////////////////////////////////////////////////////////////////////
  // one apb transfer, held until pready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fail_count++;
    err = pslverr;
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask : xfer
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end
  // test sequence
  initial begin
    cyc(2);
    presetn <= 1;
    xfer(0, OFF_POWER, 0); `CHK(rd, 32'h50)
    xfer(0, OFF_EXPO, 0); `CHK(rd, 32'h3C)
    xfer(0, OFF_THRESH, 0); `CHK(rd, 32'h41)
    xfer(0, 8'h30, 0); `CHK(err, 1'b1)
    done("defaults");
    xfer(1, OFF_POWER, 0); `CHK(err, 1'b1)
    xfer(1, OFF_POWER, 32'h65); `CHK(err, 1'b1)
    xfer(1, OFF_EXPO, 32'h2710); `CHK(err, 1'b1)
    xfer(1, OFF_THRESH, 32'h42); `CHK(err, 1'b1)
    xfer(0, OFF_POWER, 0); `CHK(rd, 32'h50)
    xfer(1, OFF_POWER, 32'h64); `CHK(err, 1'b0)
    xfer(1, OFF_EXPO, 32'h270F); `CHK(err, 1'b0)
    xfer(1, OFF_THRESH, 32'h41); `CHK(err, 1'b0)
    done("ranges");
    xfer(1, OFF_CTRL, 32'h08); cyc(3); `CHK(lamp_on, 1'b0)
    xfer(1, OFF_CTRL, 32'h0A); cyc(40); `CHK(lamp_on, 1'b1)
    `CHK(lamp_power, 7'h64)
    xfer(1, OFF_CTRL, 32'h12); cyc(3); `CHK(lamp_on, 1'b0)
    `CHK(chiller_run, 1'b1)
    cyc(550); `CHK(chiller_run, 1'b1)
    cyc(100); `CHK(chiller_run, 1'b0)
    done("manual");
    xfer(1, OFF_CTRL, 32'h42); `CHK(err, 1'b1)
    xfer(1, OFF_KEY, 32'h0000_A5C3);
    xfer(1, OFF_CTRL, 32'h42); `CHK(err, 1'b0)
    xfer(0, OFF_TOTAL, 0); `CHK(rd, 32'h0)
    xfer(1, OFF_EXPO, 32'h2);
    xfer(1, OFF_CTRL, 32'h0B); cyc(12); `CHK(lamp_on, 1'b1)
    cyc(15); `CHK(lamp_on, 1'b0)
    xfer(0, OFF_TOTAL, 0); `CHK(rd, 32'h2)
    done("auto");
    xfer(1, OFF_CTRL, 32'h0A); cyc(3); `CHK(lamp_on, 1'b1)
    temp_set <= 8'h46; cyc(4); `CHK(lamp_on, 1'b0)
    `CHK(alarm, 1'b1)
    `CHK(relay, 1'b1)
    xfer(0, OFF_STATUS, 0); `CHK(rd, 32'h3E)
    xfer(1, OFF_CTRL, 32'h0A); cyc(3); `CHK(lamp_on, 1'b0)
    temp_set <= 8'h32; cyc(5); `CHK(alarm, 1'b0)
    xfer(0, OFF_TEMP, 0); `CHK(rd, 32'h32)
    done("overheat");
    contact_req <= 1; cyc(4); `CHK(lamp_on, 1'b1)
    contact_req <= 0; cyc(4); `CHK(lamp_on, 1'b0)
    xfer(1, OFF_CTRL, 32'h0E); cyc(3); `CHK(lamp_on, 1'b1)
    xfer(1, OFF_CTRL, 32'h02); cyc(3); `CHK(lamp_on, 1'b0)
    chill_on <= 0; cyc(3);
    xfer(1, OFF_CTRL, 32'h0E); cyc(3); `CHK(lamp_on, 1'b0)
    `CHK(alarm, 1'b1)
    chill_on <= 1;
    done("interlocks");
    xfer(1, OFF_POWER, 32'h20);
    xfer(1, OFF_CTRL, 32'h20); `CHK(err, 1'b0)
    xfer(0, OFF_POWER, 0); `CHK(rd, 32'h50)
    xfer(0, OFF_THRESH, 0); `CHK(rd, 32'h41)
    done("restore");
    end_sim();
  end
endmodule : uvlic_top_bench
`default_nettype wire
